// file: ata_pkg.sv
// constants, state codes and the count helper for the strobe timing block
// assumes one 100 MHz core clock; all phase counts are in core clock cycles
//
// How it works
// - pio strobe on, then recovery count off
// - address valid setup count before strobe
// - pio write data valid at strobe on
// - pio write data held for hold count unless a new cycle starts first
// - address held through pio recovery count
// - dma word cycle is on plus off
// - dma strobe on for exact on count
// - dma read gap uses read off count
// - dma write gap uses write off count
// - dmack and selects lead first strobe
// - dmack held off plus end count
// - dma write data stable while strobe on
// - dma write data held after strobe off
// - data and address routable to alternate pins
package ata_pkg;
  localparam int           CNT_W   = 8;
  localparam logic [7:0]   CNT_RST = 8'h00;
  localparam logic [7:0]   CNT_ONE = 8'h01;
  localparam logic [1:0]   CS_IDLE = 2'h3;    // both chip selects negated
  localparam logic [2:0]   ADR_RST = 3'h0;
  localparam logic [15:0]  DAT_RST = 16'h0000;
  localparam logic [8:0]   DWL_MAX = 9'h1ff;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PSET  = 3'b001,
    ST_PSTB  = 3'b010,
    ST_PREC  = 3'b011,
    ST_DSET  = 3'b100,
    ST_DON   = 3'b101,
    ST_DOFF  = 3'b110,
    ST_DEND  = 3'b111
  } ata_state_t;

  // a programmed zero would give a phase of no length; treat it as one cycle
  function automatic logic [7:0] ata_min1(input logic [7:0] v);
    return (v == CNT_RST) ? CNT_ONE : v;
  endfunction : ata_min1
endpackage : ata_pkg

// file: ata_cnt_if.sv
// interface between the sequencer and its phase down counter
// assumes both ends run on core_clk
`timescale 1ns/10ps
interface ata_cnt_if;
  logic       load;      // start a new phase
  logic [7:0] load_val;  // phase length in cycles
  logic       hold;      // freeze the count
  logic       last;      // final cycle of the phase
  modport ctl (output load, output load_val, output hold, input last);
  modport cnt (input load, input load_val, input hold, output last);
endinterface : ata_cnt_if

// file: ata_phase_cnt.sv
// phase down counter: loaded at a phase start, flags the phase's last cycle
// assumes load values are already at least one
`timescale 1ns/10ps
module ata_phase_cnt
  import ata_pkg::*;
(
  input  wire logic core_clk,  // core clock
  input  wire logic rst,       // async reset, high
  ata_cnt_if.cnt    cif        // sequencer side
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  ////////////////////////////////////////////////////////////////////////
  // count down, hold while stretched, reload on phase change
  always_comb begin
    nxt_cnt = cnt_ff;
    if (cif.load) begin
      nxt_cnt = cif.load_val;
    end else if (!cif.hold && cnt_ff > CNT_ONE) begin
      nxt_cnt = cnt_ff - CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cif.last = (cnt_ff <= CNT_ONE);

  cnt_load_a: assert property (@(posedge core_clk) disable iff (rst)
    cif.load |=> cnt_ff == $past(cif.load_val))
    else $error("phase counter did not take its load value");
endmodule : ata_phase_cnt

// file: ata_strobe_timing.sv
// strobe sequencer for register, pio and multiword dma cycles on a drive cable
// assumes counts are stable while a cycle runs and requests come from core_clk logic
`timescale 1ns/10ps
module ata_strobe_timing
  import ata_pkg::*;
(
  input  wire logic        core_clk,              // core clock
  input  wire logic        rst,                   // async reset, high
  input  wire logic [7:0]  pio_strobe_count,      // pio strobe on cycles
  input  wire logic [7:0]  pio_recovery_count,    // pio strobe off cycles
  input  wire logic [7:0]  pio_addr_setup_count,  // address before strobe
  input  wire logic [7:0]  pio_wdata_hold_count,  // write data after strobe
  input  wire logic [7:0]  dma_strobe_on_count,   // dma strobe on cycles
  input  wire logic [7:0]  dma_strobe_off_count,  // off cycles after last word
  input  wire logic [7:0]  dma_read_off_count,    // read gap between words
  input  wire logic [7:0]  dma_write_off_count,   // write gap between words
  input  wire logic [7:0]  dma_ack_setup_count,   // dmack before first strobe
  input  wire logic [7:0]  dma_end_cycle_count,   // dmack tail after off
  input  wire logic        alt_port_sel,          // use alternate pin set
  input  wire logic        pio_req,               // start pio cycle, pulse
  input  wire logic        pio_write,             // pio direction
  input  wire logic [2:0]  pio_addr,              // register address
  input  wire logic [1:0]  pio_cs_n,              // chip selects
  input  wire logic [15:0] pio_wdata,             // pio write word
  output      logic [15:0] pio_rdata,             // pio read word
  output      logic        pio_done,              // pio cycle over, pulse
  input  wire logic        dma_start,             // start dma burst, pulse
  input  wire logic        dma_write,             // dma direction
  input  wire logic [1:0]  dma_cs_n,              // chip selects in burst
  input  wire logic        dma_more,              // more words wanted
  input  wire logic [15:0] dma_wdata,             // next dma write word
  output      logic        dma_wtake,             // dma_wdata taken, pulse
  output      logic [15:0] dma_rdata,             // dma read word
  output      logic        dma_word_done,         // word strobed, pulse
  output      logic        dma_done,              // burst over, pulse
  output      logic        busy,                  // cycle or burst active
  input  wire logic        iordy,                 // drive ready
  input  wire logic        dmarq,                 // drive dma request
  output      logic        dior_n,                // read strobe
  output      logic        diow_n,                // write strobe
  output      logic        dmack_n,               // dma acknowledge
  output      logic [1:0]  cs_n,                  // chip select pins
  output      logic [2:0]  pri_addr,              // primary address pins
  output      logic [2:0]  alt_addr,              // alternate address pins
  output      logic [15:0] pri_data_out,          // primary data out
  output      logic        pri_data_oe_n,         // primary drive enable
  input  wire logic [15:0] pri_data_in,           // primary data in
  output      logic [15:0] alt_data_out,          // alternate data out
  output      logic        alt_data_oe_n,         // alternate drive enable
  input  wire logic [15:0] alt_data_in            // alternate data in
);
  ata_cnt_if cif ();

  ata_state_t  state_ff, nxt_state;
  logic        strobe_ff, nxt_strobe;
  logic        wr_ff, nxt_wr;
  logic        dmack_ff, nxt_dmack;
  logic        cont_ff, nxt_cont;
  logic        alt_ff, nxt_alt;
  logic        doe_ff, nxt_doe;
  logic [1:0]  cs_ff, nxt_cs;
  logic [2:0]  addr_ff, nxt_addr;
  logic [15:0] dout_ff, nxt_dout;
  logic [15:0] prd_ff, nxt_prd;
  logic [15:0] drd_ff, nxt_drd;
  logic [7:0]  hold_ff, nxt_hold;
  logic        pdone_ff, nxt_pdone;
  logic        wdone_ff, nxt_wdone;
  logic        ddone_ff, nxt_ddone;
  logic        wtake_ff, nxt_wtake;
  logic [8:0]  dwell_ff, nxt_dwell;
  logic [15:0] din;

  ata_phase_cnt u_cnt (
    .core_clk (core_clk),
    .rst      (rst),
    .cif      (cif)
  );

  // read data comes from the selected pin set
  assign din = alt_ff ? alt_data_in : pri_data_in;

  ////////////////////////////////////////////////////////////////////////
  // sequencer: each phase loads the counter and waits for its last cycle
  always_comb begin
    nxt_state    = state_ff;
    nxt_strobe   = strobe_ff;
    nxt_wr       = wr_ff;
    nxt_dmack    = dmack_ff;
    nxt_cont     = cont_ff;
    nxt_alt      = alt_ff;
    nxt_doe      = doe_ff;
    nxt_cs       = cs_ff;
    nxt_addr     = addr_ff;
    nxt_dout     = dout_ff;
    nxt_prd      = prd_ff;
    nxt_drd      = drd_ff;
    nxt_pdone    = 1'b0;
    nxt_wdone    = 1'b0;
    nxt_ddone    = 1'b0;
    nxt_wtake    = 1'b0;
    cif.load     = 1'b0;
    cif.load_val = CNT_ONE;
    cif.hold     = 1'b0;
    // pio write data release runs on its own count, it may outlast recovery
    nxt_hold = (hold_ff > CNT_RST) ? hold_ff - CNT_ONE : CNT_RST;
    if (hold_ff == CNT_ONE) begin
      nxt_doe = 1'b0;
    end
    unique case (state_ff)
      ST_IDLE: begin
        nxt_alt = alt_port_sel;  // pin set only changes between cycles
        if (pio_req) begin
          nxt_addr     = pio_addr;
          nxt_cs       = pio_cs_n;
          nxt_wr       = pio_write;
          nxt_dout     = pio_wdata;
          nxt_doe      = pio_write;
          nxt_hold     = CNT_RST;
          nxt_state    = ST_PSET;
          cif.load     = 1'b1;
          cif.load_val = ata_min1(pio_addr_setup_count);
        end else if (dma_start) begin
          nxt_cs       = dma_cs_n;
          nxt_dmack    = 1'b1;
          nxt_wr       = dma_write;
          nxt_hold     = CNT_RST;
          nxt_doe      = 1'b0;
          nxt_state    = ST_DSET;
          cif.load     = 1'b1;
          cif.load_val = ata_min1(dma_ack_setup_count);
        end
      end
      ST_PSET: begin
        if (cif.last) begin
          nxt_strobe   = 1'b1;
          nxt_state    = ST_PSTB;
          cif.load     = 1'b1;
          cif.load_val = ata_min1(pio_strobe_count);
        end
      end
      ST_PSTB: begin
        cif.hold = !iordy;
        if (cif.last && iordy) begin
          nxt_strobe   = 1'b0;
          if (!wr_ff) begin
            nxt_prd = din;
          end
          if (wr_ff) begin
            nxt_hold = ata_min1(pio_wdata_hold_count);
          end
          nxt_state    = ST_PREC;
          cif.load     = 1'b1;
          cif.load_val = ata_min1(pio_recovery_count);
        end
      end
      ST_PREC: begin
        if (cif.last) begin
          nxt_cs    = CS_IDLE;
          nxt_state = ST_IDLE;
          nxt_pdone = 1'b1;
        end
      end
      ST_DSET, ST_DOFF: begin
        if (cif.last && (state_ff == ST_DSET || cont_ff)) begin
          nxt_strobe   = 1'b1;
          if (wr_ff) begin
            nxt_dout  = dma_wdata;
            nxt_doe   = 1'b1;
            nxt_wtake = 1'b1;
          end
          nxt_state    = ST_DON;
          cif.load     = 1'b1;
          cif.load_val = ata_min1(dma_strobe_on_count);
        end else if (cif.last) begin
          nxt_doe      = 1'b0;
          nxt_state    = ST_DEND;
          cif.load     = 1'b1;
          cif.load_val = ata_min1(dma_end_cycle_count);
        end
      end
      ST_DON: begin
        if (cif.last) begin
          nxt_strobe = 1'b0;
          nxt_wdone  = 1'b1;
          if (!wr_ff) begin
            nxt_drd = din;
          end
          // the drive has dropped dmarq by now if it wants the burst over
          nxt_cont     = dmarq && dma_more;
          nxt_state    = ST_DOFF;
          cif.load     = 1'b1;
          if (!(dmarq && dma_more)) begin
            cif.load_val = ata_min1(dma_strobe_off_count);
          end else if (wr_ff) begin
            cif.load_val = ata_min1(dma_write_off_count);
          end else begin
            cif.load_val = ata_min1(dma_read_off_count);
          end
        end
      end
      ST_DEND: begin
        if (cif.last) begin
          nxt_dmack = 1'b0;
          nxt_cs    = CS_IDLE;
          nxt_state = ST_IDLE;
          nxt_ddone = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff  <= ST_IDLE;
      strobe_ff <= 1'b0;
      wr_ff     <= 1'b0;
      dmack_ff  <= 1'b0;
      cont_ff   <= 1'b0;
      alt_ff    <= 1'b0;
      doe_ff    <= 1'b0;
      cs_ff     <= CS_IDLE;
      addr_ff   <= ADR_RST;
      dout_ff   <= DAT_RST;
      prd_ff    <= DAT_RST;
      drd_ff    <= DAT_RST;
      hold_ff   <= CNT_RST;
      pdone_ff  <= 1'b0;
      wdone_ff  <= 1'b0;
      ddone_ff  <= 1'b0;
      wtake_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      strobe_ff <= nxt_strobe;
      wr_ff     <= nxt_wr;
      dmack_ff  <= nxt_dmack;
      cont_ff   <= nxt_cont;
      alt_ff    <= nxt_alt;
      doe_ff    <= nxt_doe;
      cs_ff     <= nxt_cs;
      addr_ff   <= nxt_addr;
      dout_ff   <= nxt_dout;
      prd_ff    <= nxt_prd;
      drd_ff    <= nxt_drd;
      hold_ff   <= nxt_hold;
      pdone_ff  <= nxt_pdone;
      wdone_ff  <= nxt_wdone;
      ddone_ff  <= nxt_ddone;
      wtake_ff  <= nxt_wtake;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: only the selected set carries address and drives data
  assign dior_n        = !(strobe_ff && !wr_ff);
  assign diow_n        = !(strobe_ff && wr_ff);
  assign dmack_n       = !dmack_ff;
  assign cs_n          = cs_ff;
  assign pri_addr      = alt_ff ? ADR_RST : addr_ff;
  assign alt_addr      = alt_ff ? addr_ff : ADR_RST;
  assign pri_data_out  = dout_ff;
  assign alt_data_out  = dout_ff;
  assign pri_data_oe_n = !(doe_ff && !alt_ff);
  assign alt_data_oe_n = !(doe_ff && alt_ff);
  assign pio_rdata     = prd_ff;
  assign dma_rdata     = drd_ff;
  assign pio_done      = pdone_ff;
  assign dma_word_done = wdone_ff;
  assign dma_done      = ddone_ff;
  assign dma_wtake     = wtake_ff;
  assign busy          = (state_ff != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // checking aid: cycles spent in the present state
  always_comb begin
    if (nxt_state != state_ff) begin
      nxt_dwell = 9'h000;
    end else begin
      nxt_dwell = (dwell_ff == DWL_MAX) ? dwell_ff : dwell_ff + 9'h001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dwell_ff <= 9'h000;
    end else begin
      dwell_ff <= nxt_dwell;
    end
  end

  addr_setup_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_PSET && nxt_state == ST_PSTB)
      |-> dwell_ff + 9'h001 == {1'b0, ata_min1(pio_addr_setup_count)})
    else $error("address setup length wrong");
  pio_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_PSTB && nxt_state == ST_PREC)
      |-> dwell_ff + 9'h001 >= {1'b0, ata_min1(pio_strobe_count)})
    else $error("pio strobe too short");
  iordy_stall_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_PSTB && !iordy) |=> (state_ff == ST_PSTB && !strobe_ff == 1'b0))
    else $error("strobe ended while iordy low");
  pio_recov_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_PREC && nxt_state == ST_IDLE)
      |-> dwell_ff + 9'h001 == {1'b0, ata_min1(pio_recovery_count)} && $stable(addr_ff))
    else $error("recovery length or address hold wrong");
  pio_wdata_a: assert property (@(posedge core_clk) disable iff (rst)
    (!diow_n && $past(!diow_n)) |-> $stable(dout_ff) && doe_ff)
    else $error("write data moved under strobe");
  pio_whold_a: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(diow_n) && state_ff == ST_PREC) |-> doe_ff [*1])
    else $error("pio write data dropped at strobe end");
  dma_setup_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_DSET && nxt_state == ST_DON)
      |-> dmack_ff && dwell_ff + 9'h001 == {1'b0, ata_min1(dma_ack_setup_count)})
    else $error("dmack setup wrong");
  dma_on_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_DON && nxt_state == ST_DOFF)
      |-> dwell_ff + 9'h001 == {1'b0, ata_min1(dma_strobe_on_count)})
    else $error("dma strobe width wrong");
  dma_gap_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_DOFF && nxt_state == ST_DON)
      |-> dwell_ff + 9'h001 == {1'b0, ata_min1(wr_ff ? dma_write_off_count
                                                      : dma_read_off_count)})
    else $error("dma gap between words wrong");
  dma_end_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_DEND && nxt_state == ST_IDLE)
      |-> dmack_ff && dwell_ff + 9'h001 == {1'b0, ata_min1(dma_end_cycle_count)})
    else $error("dmack tail wrong");
  dma_wdata_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_DON && wr_ff && $past(state_ff) == ST_DON) |-> $stable(dout_ff))
    else $error("dma write data moved under strobe");
  alt_route_a: assert property (@(posedge core_clk) disable iff (rst)
    alt_ff |-> pri_data_oe_n && pri_addr == ADR_RST)
    else $error("primary pins active while alternate chosen");
endmodule : ata_strobe_timing

// file: ata_drive_model.sv
// drive-side model of the cable: iordy stall, dmarq word budget, read data
// assumes active-low strobes and dmack from the block, all on core_clk
`timescale 1ns/10ps
module ata_drive_model (
  input  wire logic        core_clk, // core clock
  input  wire logic        rst,      // async reset, high
  input  wire logic        dior_n,   // read strobe
  input  wire logic        diow_n,   // write strobe
  input  wire logic        dmack_n,  // dma acknowledge
  input  wire logic [7:0]  stall,    // iordy low cycles per pio strobe
  input  wire logic [7:0]  words,    // dma words before dmarq drops
  input  wire logic [15:0] rd_word,  // base of the read words
  output      logic        iordy,    // drive ready
  output      logic        dmarq,    // drive dma request
  output      logic [15:0] dout      // read data toward the block
);
  logic        stb_ff;
  logic [7:0]  scnt_ff;
  logic [7:0]  wcnt_ff;
  logic [15:0] last_ff;
  logic        fall;

  ////////////////////////////////////////////////////////////////////////////
  // strobe start seen one edge late, as a real sampler on the cable would
  assign fall = !stb_ff && !(dior_n & diow_n);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stb_ff  <= 1'b0;
      scnt_ff <= 8'h00;
      wcnt_ff <= 8'h00;
      last_ff <= 16'h0000;
    end else begin
      stb_ff  <= !(dior_n & diow_n);
      last_ff <= dout;
      if (fall && dmack_n)
        scnt_ff <= stall;
      else if (scnt_ff != 8'h00)
        scnt_ff <= scnt_ff - 8'h01;
      if (dmack_n)
        wcnt_ff <= 8'h00;
      else if (fall)
        wcnt_ff <= wcnt_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // iordy drops inside the strobe window; dmarq drops in the last word's strobe
  assign iordy = (scnt_ff == 8'h00);
  assign dmarq = dmack_n ? (words != 8'h00) : (wcnt_ff < words);
  // released bus toggles every cycle so a sample one cycle late never looks right
  assign dout  = dior_n ? ~last_ff : rd_word + {8'h00, wcnt_ff};
endmodule : ata_drive_model

// file: ata_strobe_timing_tb.sv
// self-checking bench for the strobe timing block with a drive model attached
// assumes ata_pkg, the design files and ata_drive_model are compiled first
`timescale 1ns/10ps
module ata_strobe_timing_tb;
  logic        core_clk, rst, alt_port_sel, pio_req, pio_write, dma_start, dma_write;
  logic        dma_more, pio_done, dma_wtake, dma_word_done, dma_done, busy, iordy, dmarq;
  logic        dior_n, diow_n, dmack_n, pri_data_oe_n, alt_data_oe_n;
  logic [7:0]  pio_strobe_count, pio_recovery_count, pio_addr_setup_count;
  logic [7:0]  pio_wdata_hold_count, dma_strobe_on_count, dma_strobe_off_count;
  logic [7:0]  dma_read_off_count, dma_write_off_count, dma_ack_setup_count;
  logic [7:0]  dma_end_cycle_count, stall, words;
  logic [2:0]  pio_addr, pri_addr, alt_addr;
  logic [1:0]  pio_cs_n, dma_cs_n, cs_n;
  logic [15:0] pio_wdata, dma_wdata, pio_rdata, dma_rdata, rd_word, drv_data;
  logic [15:0] pri_data_out, alt_data_out, pri_data_in, alt_data_in;
  int          n_mismatch, tests_run, cyc;

  ////////////////////////////////////////////////////////////////////////////
  // block, drive model, and the unselected data set fed a wrong word
  ata_strobe_timing u_dut (
    .core_clk, .rst, .pio_strobe_count, .pio_recovery_count, .pio_addr_setup_count,
    .pio_wdata_hold_count, .dma_strobe_on_count, .dma_strobe_off_count,
    .dma_read_off_count, .dma_write_off_count, .dma_ack_setup_count,
    .dma_end_cycle_count, .alt_port_sel, .pio_req, .pio_write, .pio_addr, .pio_cs_n,
    .pio_wdata, .pio_rdata, .pio_done, .dma_start, .dma_write, .dma_cs_n, .dma_more,
    .dma_wdata, .dma_wtake, .dma_rdata, .dma_word_done, .dma_done, .busy, .iordy,
    .dmarq, .dior_n, .diow_n, .dmack_n, .cs_n, .pri_addr, .alt_addr, .pri_data_out,
    .pri_data_oe_n, .pri_data_in, .alt_data_out, .alt_data_oe_n, .alt_data_in);
  ata_drive_model u_drive (
    .core_clk, .rst, .dior_n, .diow_n, .dmack_n, .stall, .words, .rd_word, .iordy,
    .dmarq, .dout(drv_data));
  assign pri_data_in = alt_port_sel ? ~drv_data : drv_data;
  assign alt_data_in = alt_port_sel ? drv_data : ~drv_data;

  ////////////////////////////////////////////////////////////////////////////
  // clock, hang limit and the next dma write word after each take
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (dma_wtake)
      dma_wdata <= dma_wdata + 16'h0001;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  function automatic int m1(input logic [7:0] v);
    return (v == 8'h00) ? 1 : int'(v);
  endfunction : m1

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // follow one cycle or burst at the pins, sampled mid-cycle, to its done pulse
  task automatic watch(input logic dma, wr, input int es, ep, eg, et, eh, nw,
                       input logic [15:0] wb, input logic [4:0] ea);
    int su, sl, gl, hd, k, n;
    logic prv, stb, act, oe;
    su = 0; sl = 0; gl = 0; hd = 0; k = 0; prv = 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(negedge core_clk);
      stb = !(dior_n & diow_n);
      act = dma ? !dmack_n : (cs_n != 2'h3);
      oe = alt_port_sel ? alt_data_oe_n : pri_data_oe_n;
      if (stb && !prv) begin
        if (k == 0) chk("setup", su, es);
        else chk("gap", gl, eg);
        k++; sl = 0; gl = 0; hd = 0;
      end
      if (!stb && prv) chk("strobe", sl, ep);
      if (stb) sl++;
      else if (act && k == 0) su++;
      else if (act) gl++;
      if (!stb && k > 0 && !oe) hd++;
      if (act) chk("cs", cs_n, ea[4:3]);
      if (act && !dma) chk("addr", alt_port_sel ? {alt_addr, pri_addr} : {pri_addr, alt_addr},
                           {ea[2:0], 3'h0});
      chk("idle oe", alt_port_sel ? pri_data_oe_n : alt_data_oe_n, 16'h0001);
      if (wr && stb) chk("oe", oe, 16'h0000);
      if (wr && k > 0 && (stb || !oe))
        chk("wdata", alt_port_sel ? alt_data_out : pri_data_out, wb + k - 1);
      if (dma_word_done && !wr) chk("dma rdata", dma_rdata, rd_word + k);
      if (pio_done || dma_done) break;
      prv = stb;
    end
    chk("tail", gl, et);
    chk("hold", hd, eh);
    chk("words", k, nw);
    if (!dma) chk("busy", busy, 16'h0000);
    if (!dma && !wr) chk("pio rdata", pio_rdata, rd_word);
  endtask : watch

  // request, optional refused requests while busy, and the watcher side by side
  task automatic go(input logic dma, wr, pk, input int es, ep, eg, et, eh, nw,
                    input logic [15:0] wb, input logic [4:0] ea);
    fork
      watch(dma, wr, es, ep, eg, et, eh, nw, wb, ea);
      begin
        if (dma) dma_start <= 1'b1;
        else pio_req <= 1'b1;
        @(posedge core_clk);
        dma_start <= 1'b0;
        pio_req <= 1'b0;
        if (pk) begin
          @(posedge core_clk);
          pio_req <= 1'b1;
          dma_start <= 1'b1;
          pio_addr <= ~pio_addr;
          @(posedge core_clk);
          pio_req <= 1'b0;
          dma_start <= 1'b0;
        end
      end
    join
  endtask : go

  task automatic pio(input logic wr, a, pk, input logic [7:0] s, p, r, h, st);
    logic [15:0] wd;
    wd = 16'h5a00 + s;
    @(posedge core_clk);
    alt_port_sel <= a;
    pio_write <= wr;
    stall <= st;
    pio_addr_setup_count <= s;
    pio_strobe_count <= p;
    pio_recovery_count <= r;
    pio_wdata_hold_count <= h;
    pio_cs_n <= {~wr, wr};
    pio_addr <= {a, wr, 1'b1};
    pio_wdata <= wd;
    rd_word <= 16'h3c00 + p;
    @(posedge core_clk);
    go(1'b0, wr, pk, m1(s), m1(p) + st, 0, m1(r), wr ? m1(h) : 0, 1, wd,
       {~wr, wr, a, wr, 1'b1});
  endtask : pio

  // the unused gap count is set apart so a swapped gap shows up
  task automatic dma(input logic wr, a, mo, input logic [7:0] w, m, d, g, k, e);
    @(posedge core_clk);
    alt_port_sel <= a;
    dma_write <= wr;
    dma_more <= mo;
    words <= w;
    dma_cs_n <= {wr, ~wr};
    dma_ack_setup_count <= m;
    dma_strobe_on_count <= d;
    dma_read_off_count <= wr ? g + 8'h03 : g;
    dma_write_off_count <= wr ? g : g + 8'h03;
    dma_strobe_off_count <= k;
    dma_end_cycle_count <= e;
    dma_wdata <= 16'hc000 + w;
    rd_word <= 16'h7100 + d;
    @(posedge core_clk);
    go(1'b1, wr, 1'b0, m1(m), m1(d), m1(g), m1(k) + m1(e), wr ? m1(k) : 0, mo ? w : 1,
       16'hc000 + w, {wr, ~wr, 3'h0});
  endtask : dma

  ////////////////////////////////////////////////////////////////////////////
  // reset, then pio and dma cases on both pin sets with boundary counts
  initial begin
    {alt_port_sel, pio_req, pio_write, dma_start, dma_write, dma_more} = '0;
    {pio_strobe_count, pio_recovery_count, pio_addr_setup_count, pio_wdata_hold_count,
     dma_strobe_on_count, dma_strobe_off_count, dma_read_off_count, dma_write_off_count,
     dma_ack_setup_count, dma_end_cycle_count, stall, words} = '0;
    {pio_addr, pio_cs_n, dma_cs_n, pio_wdata, dma_wdata, rd_word} = '0;
    n_mismatch = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    chk("reset pins", {dior_n, diow_n, dmack_n, cs_n, pri_data_oe_n, alt_data_oe_n, busy},
        16'h00fe);
    rst <= 1'b0;
    pio(1'b1, 1'b0, 1'b0, 8'h01, 8'h02, 8'h02, 8'h01, 8'h00);
    pio(1'b0, 1'b0, 1'b0, 8'h02, 8'h03, 8'h03, 8'h00, 8'h02);
    pio(1'b1, 1'b1, 1'b1, 8'h03, 8'h04, 8'h04, 8'h02, 8'h00);
    pio(1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
    dma(1'b0, 1'b0, 1'b1, 8'h03, 8'h02, 8'h03, 8'h02, 8'h01, 8'h02);
    dma(1'b1, 1'b0, 1'b1, 8'h03, 8'h01, 8'h03, 8'h04, 8'h02, 8'h01);
    dma(1'b0, 1'b1, 1'b0, 8'h04, 8'h01, 8'h03, 8'h02, 8'h01, 8'h01);
    dma(1'b1, 1'b1, 1'b1, 8'h01, 8'h00, 8'h03, 8'h02, 8'h00, 8'h00);
    repeat (4) @(posedge core_clk);
    results();
  end
endmodule : ata_strobe_timing_tb
